//--- pkg/opr_regs.vh
`ifndef OPR_REGS_VH
`define OPR_REGS_VH

// host address fields
`define OPR_PORT_HI 7
`define OPR_PORT_LO 5
`define OPR_SECT_BIT 4
`define OPR_OFF_HI 4
`define OPR_OFF_LO 0

// register offsets inside a port slot (section bit and index together)
`define OPR_OFF_TX_SHARED_CONFIG 5'h00
`define OPR_OFF_TX_COUNT_LATCH 5'h01
`define OPR_OFF_TX_CELL_COUNT_HIGH 5'h02
`define OPR_OFF_TX_CELL_COUNT_LOW 5'h03
`define OPR_OFF_TX_IDLE_PAYLOAD 5'h04
`define OPR_OFF_TX_HEC_PATTERN 5'h05
`define OPR_OFF_TX_CONTROL_ONE 5'h06
`define OPR_OFF_TX_CONTROL_TWO 5'h07
`define OPR_OFF_INTERRUPT_STATUS 5'h08
`define OPR_OFF_RX_SHARED_CONFIG 5'h10
`define OPR_OFF_RX_DELINEATION 5'h11
`define OPR_OFF_RX_COUNT_LATCH 5'h12
`define OPR_OFF_RX_CORR_HEC 5'h13
`define OPR_OFF_RX_UNCORR_HIGH 5'h14
`define OPR_OFF_RX_UNCORR_LOW 5'h15
`define OPR_OFF_RX_CELL_COUNT_HIGH 5'h16
`define OPR_OFF_RX_CELL_COUNT_LOW 5'h17
`define OPR_OFF_PORT_STATUS 5'h18
`define OPR_OFF_RX_CONTROL_ONE 5'h19
`define OPR_OFF_RX_CONTROL_TWO 5'h1a
`define OPR_OFF_RX_FILTER_CONTROL 5'h1b
`define OPR_OFF_RX_FILTER_MATCH_ONE 5'h1c
`define OPR_OFF_RX_FILTER_MATCH_TWO 5'h1d
`define OPR_OFF_RX_FILTER_MATCH_THREE 5'h1e
`define OPR_OFF_RX_FILTER_MATCH_FOUR 5'h1f

// slots of the per-port configuration store
`define OPR_SLOT_TX_CONTROL_ONE 4'h0
`define OPR_SLOT_TX_CONTROL_TWO 4'h1
`define OPR_SLOT_RX_CONTROL_ONE 4'h2
`define OPR_SLOT_RX_CONTROL_TWO 4'h3
`define OPR_SLOT_RX_FILTER_CONTROL 4'h4
`define OPR_SLOT_RX_FILTER_MATCH_ONE 4'h5

// slots of the per-block shared store
`define OPR_SH_TX_CONFIG 3'h0
`define OPR_SH_TX_IDLE 3'h1
`define OPR_SH_TX_HEC 3'h2
`define OPR_SH_RX_CONFIG 3'h3
`define OPR_SH_RX_DELIN 3'h4

// reset values
`define OPR_RST_TX_SHARED_CONFIG 8'h10
`define OPR_RST_TX_CONTROL_ONE 8'h05
`define OPR_RST_ZERO 8'h00

// counter widths and saturation limits
`define OPR_CNT16_MAX 16'hffff
`define OPR_CORR_MAX 8'hff
`define OPR_UNCORR_MAX 12'hfff

// sizes
`define OPR_NPORT 16
`define OPR_CFG_DEPTH 256
`define OPR_SH_DEPTH 16

`endif

//--- core/opr_port_counters.v
`timescale 1ns/1ps
`include "opr_regs.vh"

// performance counters of one port; all saturate at their top value
module opr_port_counters (
   input wire clk_sys,
   input wire arst_n,
   input wire tx_cell_evt,
   input wire rx_cell_evt,
   input wire rx_corr_evt,
   input wire rx_uncorr_evt,
   input wire tx_clear,
   input wire rx_clear,
   output reg [15:0] tx_count_q,
   output reg [15:0] rx_count_q,
   output reg [7:0] corr_count_q,
   output reg [11:0] uncorr_count_q
);

   // an event in the clearing cycle is counted, so the new count is one
   function [15:0] opr_sat_inc;
      input [15:0] cur;
      input [15:0] lim;
      input evt;
      input clr;
      begin
         if (clr) begin
            opr_sat_inc = evt ? 16'h0001 : 16'h0000;
         end else if (evt && cur != lim) begin
            opr_sat_inc = cur + 16'h0001;
         end else begin
            opr_sat_inc = cur;
         end
      end
   endfunction

   wire [15:0] corr_ext;
   wire [15:0] uncorr_ext;
   wire [15:0] corr_next;
   wire [15:0] uncorr_next;

   assign corr_ext = {8'h00, corr_count_q};
   assign uncorr_ext = {4'h0, uncorr_count_q};
   assign corr_next = opr_sat_inc(corr_ext, {8'h00, `OPR_CORR_MAX}, rx_corr_evt, rx_clear);
   assign uncorr_next = opr_sat_inc(uncorr_ext, {4'h0, `OPR_UNCORR_MAX}, rx_uncorr_evt,
      rx_clear);

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tx_count_q <= 16'h0000;
         rx_count_q <= 16'h0000;
         corr_count_q <= 8'h00;
         uncorr_count_q <= 12'h000;
      end else begin
         tx_count_q <= opr_sat_inc(tx_count_q, `OPR_CNT16_MAX, tx_cell_evt, tx_clear); // R17
         rx_count_q <= opr_sat_inc(rx_count_q, `OPR_CNT16_MAX, rx_cell_evt, rx_clear); // R17
         corr_count_q <= corr_next[7:0];
         uncorr_count_q <= uncorr_next[11:0];
      end
   end

endmodule

//--- core/opr_reg_decoder.v
`timescale 1ns/1ps
`include "opr_regs.vh"

//
// Contract
// R01: eight-bit registers, one copy per port
// R02: address bits 7..5 pick the port
// R03: address bit 4 picks tx or rx
// R04: address bits 3..0 pick the register
// R05: block select picks one of two octals
// R06: shared registers live in port one only
// R07: tx latch write copies tx count
// R08: latched count readable from every port slot
// R09: upper byte bits 15..8, lower 7..0
// R10: rx latch write copies rx count
// R11: per-port hec latch and split count
// R12: per-port status, control, filter registers
// R13: host avoids reserved addresses
// R14: host writes zero to reserved bits
// R15: access classes are honoured
// R16: bit 7 is the byte msb
// R17: latch write clears the source count
// R18: reserved reads zero, writes ignored
// R19: latch copy is atomic
//
module opr_reg_decoder (
   input wire clk_sys,
   input wire arst_n,
   input wire octal_block_select,
   input wire [7:0] host_addr,
   input wire [7:0] host_wdata,
   input wire host_wr_en,
   input wire host_rd_en,
   output reg [7:0] host_rdata_q,
   output reg host_rd_valid_q,
   input wire [15:0] tx_cell_evt,
   input wire [15:0] rx_cell_evt,
   input wire [15:0] rx_corr_evt,
   input wire [15:0] rx_uncorr_evt,
   input wire [127:0] port_status_in,
   input wire [15:0] interrupt_status_in,
   output wire [15:0] tx_shared_config,
   output wire [15:0] tx_idle_payload_byte,
   output wire [15:0] tx_hec_error_pattern,
   output wire [15:0] rx_shared_config,
   output wire [15:0] rx_delineation_integration,
   output wire [127:0] tx_control_one,
   output wire [127:0] tx_control_two,
   output wire [127:0] rx_control_one,
   output wire [127:0] rx_control_two,
   output wire [127:0] rx_user_filter_control,
   output wire [127:0] rx_user_filter_match_one,
   output wire [127:0] rx_user_filter_match_two,
   output wire [127:0] rx_user_filter_match_three,
   output wire [127:0] rx_user_filter_match_four
);

   // per-port read/write store slot: {valid, slot}
   function [4:0] opr_cfg_slot;
      input [4:0] off;
      begin
         case (off)
            `OPR_OFF_TX_CONTROL_ONE: opr_cfg_slot = {1'b1, `OPR_SLOT_TX_CONTROL_ONE};
            `OPR_OFF_TX_CONTROL_TWO: opr_cfg_slot = {1'b1, `OPR_SLOT_TX_CONTROL_TWO};
            `OPR_OFF_RX_CONTROL_ONE: opr_cfg_slot = {1'b1, `OPR_SLOT_RX_CONTROL_ONE};
            `OPR_OFF_RX_CONTROL_TWO: opr_cfg_slot = {1'b1, `OPR_SLOT_RX_CONTROL_TWO};
            `OPR_OFF_RX_FILTER_CONTROL: opr_cfg_slot = {1'b1, `OPR_SLOT_RX_FILTER_CONTROL};
            `OPR_OFF_RX_FILTER_MATCH_ONE,
            `OPR_OFF_RX_FILTER_MATCH_TWO,
            `OPR_OFF_RX_FILTER_MATCH_THREE,
            `OPR_OFF_RX_FILTER_MATCH_FOUR:
               opr_cfg_slot = {1'b1, `OPR_SLOT_RX_FILTER_MATCH_ONE + {2'b00, off[1:0]}};
            default: opr_cfg_slot = 5'h00;
         endcase
      end
   endfunction

   // shared store slot: {valid, slot}; only meaningful in the first port slot
   function [3:0] opr_shared_slot;
      input [4:0] off;
      begin
         case (off)
            `OPR_OFF_TX_SHARED_CONFIG: opr_shared_slot = {1'b1, `OPR_SH_TX_CONFIG};
            `OPR_OFF_TX_IDLE_PAYLOAD: opr_shared_slot = {1'b1, `OPR_SH_TX_IDLE};
            `OPR_OFF_TX_HEC_PATTERN: opr_shared_slot = {1'b1, `OPR_SH_TX_HEC};
            `OPR_OFF_RX_SHARED_CONFIG: opr_shared_slot = {1'b1, `OPR_SH_RX_CONFIG};
            `OPR_OFF_RX_DELINEATION: opr_shared_slot = {1'b1, `OPR_SH_RX_DELIN};
            default: opr_shared_slot = 4'h0;
         endcase
      end
   endfunction

   // address split
   wire [2:0] addr_port;
   wire addr_rx;
   wire [4:0] addr_off;
   wire [3:0] gport;
   wire first_port;
   wire [4:0] cfg_sel;
   wire [3:0] sh_sel;
   wire [7:0] cfg_idx;
   wire [3:0] sh_idx;

   assign addr_port = host_addr[`OPR_PORT_HI:`OPR_PORT_LO]; // R02
   assign addr_rx = host_addr[`OPR_SECT_BIT]; // R03
   assign addr_off = {addr_rx, host_addr[3:0]}; // R04
   assign gport = {octal_block_select, addr_port}; // R05
   assign first_port = (addr_port == 3'h0);
   assign cfg_sel = opr_cfg_slot(addr_off);
   assign sh_sel = opr_shared_slot(addr_off);
   assign cfg_idx = {gport, cfg_sel[3:0]}; // R01
   assign sh_idx = {octal_block_select, sh_sel[2:0]};

   // write decode; strobes act only on the exact write-only offsets
   // a read in the same cycle is served independently
   wire wr_cfg;
   wire wr_shared;
   wire wr_tx_latch;
   wire wr_rx_latch;

   assign wr_cfg = host_wr_en && cfg_sel[4]; // R12
   assign wr_shared = host_wr_en && sh_sel[3] && first_port; // R06 R18
   assign wr_tx_latch = host_wr_en && (addr_off == `OPR_OFF_TX_COUNT_LATCH); // R15
   assign wr_rx_latch = host_wr_en && (addr_off == `OPR_OFF_RX_COUNT_LATCH); // R15

   // performance counters, one set per port
   // a latch strobe clears only the port that it addresses
   wire [15:0] tx_cnt [0:`OPR_NPORT-1];
   wire [15:0] rx_cnt [0:`OPR_NPORT-1];
   wire [7:0] corr_cnt [0:`OPR_NPORT-1];
   wire [11:0] uncorr_cnt [0:`OPR_NPORT-1];
   wire [15:0] tx_clear;
   wire [15:0] rx_clear;

   genvar p;
   generate
      for (p = 0; p < `OPR_NPORT; p = p + 1) begin : g_port
         assign tx_clear[p] = wr_tx_latch && (gport == p); // R17
         assign rx_clear[p] = wr_rx_latch && (gport == p); // R17

         opr_port_counters u_cnt (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .tx_cell_evt(tx_cell_evt[p]),
            .rx_cell_evt(rx_cell_evt[p]),
            .rx_corr_evt(rx_corr_evt[p]),
            .rx_uncorr_evt(rx_uncorr_evt[p]),
            .tx_clear(tx_clear[p]),
            .rx_clear(rx_clear[p]),
            .tx_count_q(tx_cnt[p]),
            .rx_count_q(rx_cnt[p]),
            .corr_count_q(corr_cnt[p]),
            .uncorr_count_q(uncorr_cnt[p])
         );
      end
   endgenerate

   // storage
   reg [7:0] cfg_q [0:`OPR_CFG_DEPTH-1];
   reg [7:0] shared_q [0:`OPR_SH_DEPTH-1];
   // one latched pair per octal block, shared by its eight ports
   reg [15:0] tx_latch_q [0:1];
   reg [15:0] rx_latch_q [0:1];
   reg [7:0] corr_hold_q [0:`OPR_NPORT-1];
   reg [11:0] uncorr_hold_q [0:`OPR_NPORT-1];
   integer i_cfg;
   integer i_sh;
   integer i_lat;

   // configuration stores; reset loops cover the whole array
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (i_cfg = 0; i_cfg < `OPR_CFG_DEPTH; i_cfg = i_cfg + 1) begin
            if (i_cfg % 16 == 0) begin
               cfg_q[i_cfg] <= `OPR_RST_TX_CONTROL_ONE;
            end else begin
               cfg_q[i_cfg] <= `OPR_RST_ZERO;
            end
         end
      end else if (wr_cfg) begin
         cfg_q[cfg_idx] <= host_wdata; // R01 R12
      end
   end

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (i_sh = 0; i_sh < `OPR_SH_DEPTH; i_sh = i_sh + 1) begin
            if (i_sh % 8 == 0) begin
               shared_q[i_sh] <= `OPR_RST_TX_SHARED_CONFIG;
            end else begin
               shared_q[i_sh] <= `OPR_RST_ZERO;
            end
         end
      end else if (wr_shared) begin
         shared_q[sh_idx] <= host_wdata; // R06
      end
   end

   // latch copies take the count of the same edge as the clear, so the
   // two bytes always come from one sample and no event falls between
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tx_latch_q[0] <= 16'h0000;
         tx_latch_q[1] <= 16'h0000;
      end else if (wr_tx_latch) begin
         tx_latch_q[octal_block_select] <= tx_cnt[gport]; // R07 R19
      end
   end

   // the rx strobe also snapshots the hec counts below
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_latch_q[0] <= 16'h0000;
         rx_latch_q[1] <= 16'h0000;
      end else if (wr_rx_latch) begin
         rx_latch_q[octal_block_select] <= rx_cnt[gport]; // R10 R19
      end
   end

   // hec holds are stale between rx strobes of their port
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (i_lat = 0; i_lat < `OPR_NPORT; i_lat = i_lat + 1) begin
            corr_hold_q[i_lat] <= 8'h00;
            uncorr_hold_q[i_lat] <= 12'h000;
         end
      end else if (wr_rx_latch) begin
         corr_hold_q[gport] <= corr_cnt[gport]; // R11
         uncorr_hold_q[gport] <= uncorr_cnt[gport]; // R11
      end
   end

   // read mux; write-only and reserved locations read as zero
   reg [7:0] rd_mux;
   reg [15:0] tx_lat_sel;
   reg [15:0] rx_lat_sel;
   reg [11:0] uncorr_sel;

   always @* begin
      tx_lat_sel = tx_latch_q[octal_block_select];
      rx_lat_sel = rx_latch_q[octal_block_select];
      uncorr_sel = uncorr_hold_q[gport];
      rd_mux = 8'h00; // R18
      case (addr_off)
         `OPR_OFF_TX_CELL_COUNT_HIGH: begin
            rd_mux = tx_lat_sel[15:8]; // R08 R09
         end
         `OPR_OFF_TX_CELL_COUNT_LOW: begin
            rd_mux = tx_lat_sel[7:0]; // R08 R09
         end
         `OPR_OFF_RX_CELL_COUNT_HIGH: begin
            rd_mux = rx_lat_sel[15:8]; // R08 R09
         end
         `OPR_OFF_RX_CELL_COUNT_LOW: begin
            rd_mux = rx_lat_sel[7:0]; // R08 R09
         end
         `OPR_OFF_RX_CORR_HEC: begin
            rd_mux = corr_hold_q[gport]; // R11
         end
         `OPR_OFF_RX_UNCORR_HIGH: begin
            rd_mux = {4'h0, uncorr_sel[11:8]}; // R11 R16
         end
         `OPR_OFF_RX_UNCORR_LOW: begin
            rd_mux = uncorr_sel[7:0]; // R11
         end
         `OPR_OFF_PORT_STATUS: begin
            rd_mux = port_status_in[gport*8 +: 8]; // R12
         end
         `OPR_OFF_INTERRUPT_STATUS: begin
            if (first_port) begin
               rd_mux = interrupt_status_in[octal_block_select*8 +: 8]; // R06
            end
         end
         // write-only strobes keep no value to return
         `OPR_OFF_TX_COUNT_LATCH,
         `OPR_OFF_RX_COUNT_LATCH: begin
            rd_mux = 8'h00; // R15
         end
         `OPR_OFF_TX_SHARED_CONFIG,
         `OPR_OFF_TX_IDLE_PAYLOAD,
         `OPR_OFF_TX_HEC_PATTERN,
         `OPR_OFF_RX_SHARED_CONFIG,
         `OPR_OFF_RX_DELINEATION: begin
            // other port slots see these offsets as reserved
            if (first_port) begin
               rd_mux = shared_q[sh_idx]; // R06
            end
         end
         default: begin
            if (cfg_sel[4]) begin
               rd_mux = cfg_q[cfg_idx]; // R01 R12
            end
         end
      endcase
   end

   // read data appears one clock after the strobe and is held until the next read
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         host_rdata_q <= 8'h00;
      end else if (host_rd_en) begin
         host_rdata_q <= rd_mux;
      end
   end

   // valid pulses for exactly one cycle per read strobe
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         host_rd_valid_q <= 1'b0;
      end else begin
         host_rd_valid_q <= host_rd_en;
      end
   end

   // register contents drive the datapath directly
   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1) begin : g_blk
         assign tx_shared_config[b*8 +: 8] = shared_q[b*8 + `OPR_SH_TX_CONFIG];
         assign tx_idle_payload_byte[b*8 +: 8] = shared_q[b*8 + `OPR_SH_TX_IDLE];
         assign tx_hec_error_pattern[b*8 +: 8] = shared_q[b*8 + `OPR_SH_TX_HEC];
         assign rx_shared_config[b*8 +: 8] = shared_q[b*8 + `OPR_SH_RX_CONFIG];
         assign rx_delineation_integration[b*8 +: 8] = shared_q[b*8 + `OPR_SH_RX_DELIN];
      end
      for (p = 0; p < `OPR_NPORT; p = p + 1) begin : g_out
         assign tx_control_one[p*8 +: 8] = cfg_q[p*16 + `OPR_SLOT_TX_CONTROL_ONE];
         assign tx_control_two[p*8 +: 8] = cfg_q[p*16 + `OPR_SLOT_TX_CONTROL_TWO];
         assign rx_control_one[p*8 +: 8] = cfg_q[p*16 + `OPR_SLOT_RX_CONTROL_ONE];
         assign rx_control_two[p*8 +: 8] = cfg_q[p*16 + `OPR_SLOT_RX_CONTROL_TWO];
         assign rx_user_filter_control[p*8 +: 8] = cfg_q[p*16 + `OPR_SLOT_RX_FILTER_CONTROL];
         assign rx_user_filter_match_one[p*8 +: 8] =
            cfg_q[p*16 + `OPR_SLOT_RX_FILTER_MATCH_ONE];
         assign rx_user_filter_match_two[p*8 +: 8] =
            cfg_q[p*16 + `OPR_SLOT_RX_FILTER_MATCH_ONE + 1];
         assign rx_user_filter_match_three[p*8 +: 8] =
            cfg_q[p*16 + `OPR_SLOT_RX_FILTER_MATCH_ONE + 2];
         assign rx_user_filter_match_four[p*8 +: 8] =
            cfg_q[p*16 + `OPR_SLOT_RX_FILTER_MATCH_ONE + 3];
      end
   endgenerate

endmodule

//--- test/opr_reg_decoder_asserts.sv
`timescale 1ns/1ps
module opr_reg_decoder_asserts (
   input wire clk_sys,
   input wire arst_n,
   input wire octal_block_select,
   input wire [7:0] host_addr,
   input wire [7:0] host_wdata,
   input wire host_wr_en,
   input wire host_rd_en,
   input wire [7:0] host_rdata_q,
   input wire host_rd_valid_q,
   input wire [127:0] port_status_in,
   input wire [15:0] tx_shared_config,
   input wire [127:0] tx_control_one,
   input wire [127:0] rx_user_filter_match_four
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   wire [3:0] gp = {octal_block_select, host_addr[7:5]};
   wire [4:0] off = host_addr[4:0];
   wire [7:0] sel_status = port_status_in[gp*8 +: 8];
   wire shared_off = off == 5'h00 || off == 5'h04 || off == 5'h05 || off == 5'h08 ||
      off == 5'h10 || off == 5'h11;
   a_read_answer: assert property (host_rd_en |=> host_rd_valid_q)
      else $error("read not answered next cycle");
   a_valid_pulse: assert property (!host_rd_en |=> !host_rd_valid_q)
      else $error("read valid without a read");
   a_rdata_hold: assert property (!host_rd_en |=> $stable(host_rdata_q))
      else $error("read data moved without a read");
   a_reserved_read: assert property (host_rd_en && off >= 5'h09 && off <= 5'h0f
      |=> host_rdata_q == 8'h00) else $error("reserved read not zero");
   a_strobe_read: assert property (host_rd_en && (off == 5'h01 || off == 5'h12)
      |=> host_rdata_q == 8'h00) else $error("latch strobe readable");
   a_shared_slot: assert property (host_rd_en && host_addr[7:5] != 3'h0 && shared_off
      |=> host_rdata_q == 8'h00) else $error("shared offset visible outside slot 0");
   a_status_read: assert property (host_rd_en && off == 5'h18
      |=> host_rdata_q == $past(sel_status)) else $error("status byte of wrong port");
   a_ctrl_write: assert property (host_wr_en && off == 5'h06
      |=> tx_control_one[$past(gp)*8 +: 8] == $past(host_wdata))
      else $error("control write missed its port");
   a_match_write: assert property (host_wr_en && off == 5'h1f
      |=> rx_user_filter_match_four[$past(gp)*8 +: 8] == $past(host_wdata))
      else $error("filter match write missed its port");
   a_shared_write: assert property (host_wr_en && host_addr == 8'h00
      |=> tx_shared_config[$past(octal_block_select)*8 +: 8] == $past(host_wdata))
      else $error("shared config write missed its block");
   a_shared_guard: assert property (host_wr_en && host_addr[7:5] != 3'h0 && off == 5'h00
      |=> $stable(tx_shared_config)) else $error("reserved write changed shared config");
endmodule

bind opr_reg_decoder opr_reg_decoder_asserts chk (.clk_sys(clk_sys), .arst_n(arst_n),
   .octal_block_select(octal_block_select), .host_addr(host_addr), .host_wdata(host_wdata),
   .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_rdata_q(host_rdata_q),
   .host_rd_valid_q(host_rd_valid_q), .port_status_in(port_status_in),
   .tx_shared_config(tx_shared_config), .tx_control_one(tx_control_one),
   .rx_user_filter_match_four(rx_user_filter_match_four));

//--- test/opr_host_model.sv
`timescale 1ns/1ps
module opr_host_model (
   input wire clk_sys,
   output reg octal_block_select,
   output reg [7:0] host_addr,
   output reg [7:0] host_wdata,
   output reg host_wr_en,
   output reg host_rd_en,
   input wire [7:0] host_rdata_q,
   input wire host_rd_valid_q
);
   initial begin
      octal_block_select = 1'b0;
      host_addr = 8'h00;
      host_wdata = 8'h00;
      host_wr_en = 1'b0;
      host_rd_en = 1'b0;
   end
   // released lines show the inverse so a stale value never passes for a live one
   task wr(input b, input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         octal_block_select <= b;
         host_addr <= a;
         host_wdata <= d;
         host_wr_en <= 1'b1;
         @(posedge clk_sys);
         host_wr_en <= 1'b0;
         host_addr <= ~a;
         host_wdata <= ~d;
      end
   endtask
   task rd(input b, input [7:0] a, output [7:0] d, output v);
      begin
         @(posedge clk_sys);
         octal_block_select <= b;
         host_addr <= a;
         host_rd_en <= 1'b1;
         @(posedge clk_sys);
         host_rd_en <= 1'b0;
         host_addr <= ~a;
         #1;
         d = host_rdata_q;
         v = host_rd_valid_q;
      end
   endtask
endmodule

//--- test/test_octal_port_register_decoder.sv
`timescale 1ns/1ps
module test_octal_port_register_decoder;
   reg clk_sys, arst_n, v;
   reg [15:0] tx_cell_evt, rx_cell_evt, rx_corr_evt, rx_uncorr_evt, interrupt_status_in;
   reg [127:0] port_status_in;
   wire blk, wr_en, rd_en, rd_valid;
   wire [7:0] addr, wdata, rdata;
   wire [15:0] o_txc, o_idle, o_hecp, o_rxc, o_delin;
   wire [127:0] o_tc1, o_tc2, o_rc1, o_rc2, o_fc, o_m1, o_m2, o_m3, o_m4;
   reg [7:0] mdl [0:15][0:31];
   reg [7:0] d;
   reg [31:0] seed, t;
   integer error_cnt, cmp_count, i, j, n;

   opr_host_model host (.clk_sys(clk_sys), .octal_block_select(blk), .host_addr(addr),
      .host_wdata(wdata), .host_wr_en(wr_en), .host_rd_en(rd_en), .host_rdata_q(rdata),
      .host_rd_valid_q(rd_valid));
   opr_reg_decoder uut (.clk_sys(clk_sys), .arst_n(arst_n), .octal_block_select(blk),
      .host_addr(addr), .host_wdata(wdata), .host_wr_en(wr_en), .host_rd_en(rd_en),
      .host_rdata_q(rdata), .host_rd_valid_q(rd_valid), .tx_cell_evt(tx_cell_evt),
      .rx_cell_evt(rx_cell_evt), .rx_corr_evt(rx_corr_evt), .rx_uncorr_evt(rx_uncorr_evt),
      .port_status_in(port_status_in), .interrupt_status_in(interrupt_status_in),
      .tx_shared_config(o_txc), .tx_idle_payload_byte(o_idle), .tx_hec_error_pattern(o_hecp),
      .rx_shared_config(o_rxc), .rx_delineation_integration(o_delin), .tx_control_one(o_tc1),
      .tx_control_two(o_tc2), .rx_control_one(o_rc1), .rx_control_two(o_rc2),
      .rx_user_filter_control(o_fc), .rx_user_filter_match_one(o_m1),
      .rx_user_filter_match_two(o_m2), .rx_user_filter_match_three(o_m3),
      .rx_user_filter_match_four(o_m4));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   function [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
   endfunction
   function wr_ok(input [2:0] s, input [4:0] o);
      wr_ok = o == 5'h06 || o == 5'h07 || o >= 5'h19 || (s == 3'h0 && (o == 5'h00 ||
         o == 5'h04 || o == 5'h05 || o == 5'h10 || o == 5'h11));
   endfunction
   // latch strobes always get zero data
   function [7:0] wdat(input [4:0] o, input [7:0] x);
      wdat = (o == 5'h01 || o == 5'h12) ? 8'h00 : x;
   endfunction

   task chk(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task w(input [3:0] p, input [4:0] o, input [7:0] x);
      begin
         host.wr(p[3], {p[2:0], o}, x);
         if (wr_ok(p[2:0], o))
            mdl[p][o] = x;
      end
   endtask
   task r(input [3:0] p, input [4:0] o);
      begin
         host.rd(p[3], {p[2:0], o}, d, v);
         chk(d, mdl[p][o]);
         chk({7'h00, v}, 8'h01);
      end
   endtask
   task rd_all;
      for (i = 0; i < 16; i = i + 1)
         for (j = 0; j < 32; j = j + 1)
            r(i, j);
   endtask
   // register outputs must mirror what a read returns
   task out_chk;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            chk(o_tc1[i*8 +: 8], mdl[i][5'h06]);
            chk(o_tc2[i*8 +: 8], mdl[i][5'h07]);
            chk(o_rc1[i*8 +: 8], mdl[i][5'h19]);
            chk(o_rc2[i*8 +: 8], mdl[i][5'h1a]);
            chk(o_fc[i*8 +: 8], mdl[i][5'h1b]);
            chk(o_m1[i*8 +: 8], mdl[i][5'h1c]);
            chk(o_m2[i*8 +: 8], mdl[i][5'h1d]);
            chk(o_m3[i*8 +: 8], mdl[i][5'h1e]);
            chk(o_m4[i*8 +: 8], mdl[i][5'h1f]);
         end
         for (i = 0; i < 2; i = i + 1) begin
            chk(o_txc[i*8 +: 8], mdl[i*8][5'h00]);
            chk(o_idle[i*8 +: 8], mdl[i*8][5'h04]);
            chk(o_hecp[i*8 +: 8], mdl[i*8][5'h05]);
            chk(o_rxc[i*8 +: 8], mdl[i*8][5'h10]);
            chk(o_delin[i*8 +: 8], mdl[i*8][5'h11]);
         end
      end
   endtask
   task set_blk(input b, input [4:0] o, input [7:0] x);
      integer k;
      for (k = 0; k < 8; k = k + 1)
         mdl[{b, k[2:0]}][o] = x;
   endtask
   task ev(input [3:0] p, input integer nt, input integer nr, input integer nc,
      input integer nu);
      integer k;
      begin
         for (k = 0; k < nt || k < nr || k < nc || k < nu; k = k + 1) begin
            @(posedge clk_sys);
            tx_cell_evt <= (k < nt) ? (16'h0001 << p) : 16'h0000;
            rx_cell_evt <= (k < nr) ? (16'h0001 << p) : 16'h0000;
            rx_corr_evt <= (k < nc) ? (16'h0001 << p) : 16'h0000;
            rx_uncorr_evt <= (k < nu) ? (16'h0001 << p) : 16'h0000;
         end
         @(posedge clk_sys);
         {tx_cell_evt, rx_cell_evt, rx_corr_evt, rx_uncorr_evt} <= 64'h0;
      end
   endtask
   // events after the latch must leave the snapshot alone and become the next count
   task lat_chk(input [3:0] p, input [15:0] tc, input [15:0] rc, input integer nc,
      input [11:0] uc);
      reg [3:0] q;
      begin
         t = rnd();
         q = {p[3], t[2:0]};
         w(p, 5'h01, 8'h00);
         w(p, 5'h12, 8'h00);
         set_blk(p[3], 5'h02, tc[15:8]);
         set_blk(p[3], 5'h03, tc[7:0]);
         set_blk(p[3], 5'h16, rc[15:8]);
         set_blk(p[3], 5'h17, rc[7:0]);
         mdl[p][5'h13] = (nc > 255) ? 8'hff : nc[7:0];
         mdl[p][5'h14] = {4'h0, uc[11:8]};
         mdl[p][5'h15] = uc[7:0];
         ev(p, 3, 5, 1, 2);
         r(q, 5'h02);
         r(q, 5'h03);
         r(q, 5'h16);
         r(q, 5'h17);
         r(p, 5'h13);
         r(p, 5'h14);
         r(p, 5'h15);
      end
   endtask

   task end_sim;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
         if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      end_sim;
   end

   initial begin
      seed = 32'h17d1;
      error_cnt = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      {tx_cell_evt, rx_cell_evt, rx_corr_evt, rx_uncorr_evt} = 64'h0;
      port_status_in = 128'h0;
      interrupt_status_in = 16'h0;
      for (i = 0; i < 16; i = i + 1)
         for (j = 0; j < 32; j = j + 1)
            mdl[i][j] = (j == 6) ? 8'h05 : ((j == 0 && i[2:0] == 3'h0) ? 8'h10 : 8'h00);
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      t = rnd();
      interrupt_status_in <= t[15:0];
      port_status_in <= {rnd(), rnd(), rnd(), rnd()};
      @(posedge clk_sys);
      for (i = 0; i < 16; i = i + 1)
         mdl[i][5'h18] = port_status_in[i*8 +: 8];
      mdl[0][5'h08] = interrupt_status_in[7:0];
      mdl[8][5'h08] = interrupt_status_in[15:8];
      rd_all;
      out_chk;
      for (j = 0; j < 32; j = j + 1) begin
         t = rnd();
         w(4'h0, j, wdat(j, t[7:0]));
         w(4'hd, j, wdat(j, t[15:8]));
      end
      for (i = 0; i < 150; i = i + 1) begin
         t = rnd();
         w(t[11:8], t[16:12], wdat(t[16:12], t[7:0]));
      end
      rd_all;
      out_chk;
      for (i = 0; i < 4; i = i + 1) begin
         t = rnd();
         j = (i == 0) ? 300 : t[15:10];
         n = (i == 0) ? 300 : t[7:0];
         ev(i * 5, n, t[9:2], j, n + t[13:6]);
         lat_chk(i * 5, n, t[9:2], j, n + t[13:6]);
         lat_chk(i * 5, 16'h0003, 16'h0005, 1, 12'h002);
      end
      end_sim;
   end
endmodule
